// ==== core/servo_io_pkg.sv ====
`default_nettype none
package servo_io_pkg;
    // ==========================================================
    // Sizes and reset values
    localparam int          NUM_AXES      = 4;
    localparam int          CMD_W         = 16;
    localparam logic [15:0] VEL_ZERO_CODE = 16'h8000;
    localparam int          KP_W          = 8;
    localparam logic [7:0]  KP_RESET      = 8'h01;
    localparam int          RATE_W        = 16;
    localparam int          POS_W         = 32;
    localparam int          SYNC_STAGES   = 2;
    localparam logic        OUT_OFF       = 1'b1;

    typedef enum logic [1:0] {FMT_AB, FMT_CWCCW, FMT_PULSEDIR} pulse_fmt_t;
    typedef enum logic [1:0] {MULT_X0, MULT_X1, MULT_X2, MULT_X4} enc_mult_t;

    // ==========================================================
    // Per-axis command and feedback carriers
    typedef struct packed {
        logic [15:0] vel_cmd;
        logic [15:0] pos_target;
        logic [7:0]  kp;
        logic        loop_en;
        pulse_fmt_t  fmt;
        enc_mult_t   mult;
        logic [15:0] rate_div;
        logic        step_req;
        logic        step_dir;
    } axis_ctrl_t;

    typedef struct packed {
        logic [31:0] enc_count;
        logic        pos_limit;
        logic        neg_limit;
        logic        home;
    } axis_stat_t;
endpackage
`default_nettype wire

// ==== core/quad_decoder.sv ====
`timescale 1ns/10ps
`default_nettype none
module quad_decoder
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      phase_a,
    input  wire logic                      phase_b,
    input  wire servo_io_pkg::enc_mult_t   mult,
    output logic [servo_io_pkg::POS_W-1:0] count
);
    import servo_io_pkg::*;

    logic [1:0]       a_sync;
    logic [1:0]       b_sync;
    logic             a_prev;
    logic             b_prev;
    logic             next_a_prev;
    logic             next_b_prev;
    logic [POS_W-1:0] next_count;
    logic             step;
    logic             up;

    // ==========================================================
    // Decoding
    always_comb
    begin
        next_a_prev = a_sync[1];
        next_b_prev = b_sync[1];
        next_count  = count;
        up          = (a_prev ^ b_sync[1]);
        step        = 1'b0;
        case (mult)
            MULT_X0: step = 1'b0;
            MULT_X1: step = a_sync[1] & ~a_prev;
            MULT_X2: step = a_sync[1] ^ a_prev;
            MULT_X4: step = (a_sync[1] ^ a_prev) | (b_sync[1] ^ b_prev);
            default: step = 1'b0;
        endcase
        if (step) // [R5]
        begin
            next_count = up ? count + 32'h00000001 : count - 32'h00000001;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            a_sync <= 2'h0;
            b_sync <= 2'h0;
            a_prev <= 1'b0;
            b_prev <= 1'b0;
            count  <= 32'h00000000;
        end
        else if (ce)
        begin
            a_sync <= {a_sync[0], phase_a};
            b_sync <= {b_sync[0], phase_b};
            a_prev <= next_a_prev;
            b_prev <= next_b_prev;
            count  <= next_count;
        end
    end

    AST_X0_HOLDS: assert property (@(posedge clk) disable iff (rst)
        (ce && mult == MULT_X0) |=> $stable(count)) // [R5]
        else $error("count moved with input blocked");
endmodule
`default_nettype wire

// ==== core/four_axis_servo_io_control.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1 - Four 16-bit velocity command channels, each holding the zero-volt code after reset.
// R2 - Each axis separately runs proportional closed-loop control or passes its command.
// R3 - Four axes of pulse command outputs, one output pair per axis.
// R4 - Pulse format per axis: A/B quadrature, CW/CCW, or pulse plus direction.
// R5 - Encoder count multiplier per axis: x0 blocked, x1, x2 or x4.
// R6 - Thirteen inputs: per-axis positive, negative limit and home, one shared stop.
// R7 - Inputs read 0 when energised and active, 1 when inactive; the stop input here acts at 1 and idles at 0.
// R8 - Stop input at 1 disables all pulses and forces velocity outputs to zero.
// R9 - A latch captures the stop event so software reads it after recovery.
// R10 - Fitted bypass strap suppresses the stop action; fitted by default.
// R11 - Five outputs: one servo enable per axis and one position ready.
// R12 - Outputs active low: 0 turns the open-collector stage on.
// R13 - Servo enable written 0 makes that output conduct.
// R14 - Position ready written 0 asserts the position ready output.
// R15 - Every local input is synchronised before any use; the bypass strap feeds the stop logic unsynchronised.
module four_axis_servo_io_control
(
    input  wire logic                                         clk,
    input  wire logic                                         rst,
    input  wire logic                                         ce,
    input  wire servo_io_pkg::axis_ctrl_t [3:0]               axis_ctrl,
    input  wire logic [3:0]                                   servo_enable_value,
    input  wire logic                                         pos_ready_value,
    input  wire logic                                         estop_latch_clear,
    input  wire logic                                         estop_bypass_strap,
    input  wire logic [3:0]                                   positive_limit_in,
    input  wire logic [3:0]                                   negative_limit_in,
    input  wire logic [3:0]                                   home_in,
    input  wire logic                                         estop_in,
    input  wire logic [3:0]                                   axis_encoder_phase_a_in,
    input  wire logic [3:0]                                   axis_encoder_phase_b_in,
    output logic [3:0][servo_io_pkg::CMD_W-1:0]               axis_velocity_cmd_out,
    output logic [3:0]                                        axis_pulse_cmd_out,
    output logic [3:0]                                        axis_pulse_cmd_b_out,
    output logic [3:0]                                        servo_enable_out,
    output logic                                              pos_ready_out,
    output servo_io_pkg::axis_stat_t [3:0]                    axis_stat,
    output logic                                              estop_active,
    output logic                                              estop_latched
);
    import servo_io_pkg::*;

    // ==========================================================
    // Input synchronisers
    logic [1:0][12:0] in_sync;
    logic [12:0]      in_s;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Stop stage idles at run level so reset raises no false stop event
            in_sync <= {2{13'h0FFF}};
        end
        else if (ce)
        begin
            in_sync[0] <= {estop_in, home_in, negative_limit_in, positive_limit_in}; // [R15] [R6]
            in_sync[1] <= in_sync[0];
        end
    end

    assign in_s = in_sync[1];

    // ==========================================================
    // Emergency stop and local outputs
    logic stop_now;
    logic next_estop_active;
    logic next_estop_latched;
    logic [3:0] next_servo_enable_out;
    logic next_pos_ready_out;

    always_comb
    begin
        stop_now              = in_s[12] & ~estop_bypass_strap;               // [R8] [R10] [R7]
        next_estop_active     = stop_now;
        next_estop_latched    = estop_latched;
        if (estop_latch_clear)
        begin
            next_estop_latched = 1'b0;
        end
        if (stop_now)
        begin
            next_estop_latched = 1'b1;                                         // [R9]
        end
        next_servo_enable_out = servo_enable_value;                            // [R11] [R12] [R13]
        next_pos_ready_out    = pos_ready_value;                               // [R14]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            estop_active     <= 1'b0;
            estop_latched    <= 1'b0;
            servo_enable_out <= {4{OUT_OFF}};
            pos_ready_out    <= OUT_OFF;
        end
        else if (ce)
        begin
            estop_active     <= next_estop_active;
            estop_latched    <= next_estop_latched;
            servo_enable_out <= next_servo_enable_out;
            pos_ready_out    <= next_pos_ready_out;
        end
    end

    // ==========================================================
    // Per-axis logic
    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++)
        begin : g_axis
            logic [POS_W-1:0]  enc;
            logic [RATE_W-1:0] div_cnt;
            logic [RATE_W-1:0] next_div_cnt;
            logic [1:0]        phase;
            logic [1:0]        next_phase;
            logic              pa;
            logic              pb;
            logic              next_pa;
            logic              next_pb;
            logic [CMD_W-1:0]  vel;
            logic [CMD_W-1:0]  next_vel;
            logic signed [POS_W+KP_W:0] err_scaled;
            logic signed [POS_W:0]      err;
            logic signed [CMD_W:0]      clip;
            logic              tick;

            quad_decoder u_dec
            (
                .clk     (clk),
                .rst     (rst),
                .ce      (ce),
                .phase_a (axis_encoder_phase_a_in[g]),
                .phase_b (axis_encoder_phase_b_in[g]),
                .mult    (axis_ctrl[g].mult),
                .count   (enc)
            );

            always_comb
            begin
                err  = $signed({{17{axis_ctrl[g].pos_target[15]}}, axis_ctrl[g].pos_target})
                     - $signed({enc[POS_W-1], enc});
                err_scaled = err * $signed({1'b0, axis_ctrl[g].kp});
                if (err_scaled > 41'sd32767)
                    clip = 17'sd32767;
                else if (err_scaled < -41'sd32768)
                    clip = -17'sd32768;
                else
                    clip = err_scaled[CMD_W:0];
                if (estop_active)
                    next_vel = VEL_ZERO_CODE;                                   // [R8]
                else if (axis_ctrl[g].loop_en)
                    next_vel = clip[CMD_W-1:0] ^ VEL_ZERO_CODE;                 // [R2]
                else
                    next_vel = axis_ctrl[g].vel_cmd;                            // [R1]

                tick         = (div_cnt == axis_ctrl[g].rate_div);
                next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
                next_phase   = phase;
                next_pa      = 1'b0;
                next_pb      = (axis_ctrl[g].fmt == FMT_PULSEDIR) ? axis_ctrl[g].step_dir : 1'b0;
                if (estop_active)
                begin
                    next_div_cnt = 16'h0000;                                    // [R8]
                    next_pb      = 1'b0;
                end
                else if (axis_ctrl[g].step_req)
                begin
                    case (axis_ctrl[g].fmt)                                     // [R4] [R3]
                        FMT_AB:
                        begin
                            if (tick)
                                next_phase = axis_ctrl[g].step_dir ? phase + 2'h1 : phase - 2'h1;
                            next_pa = next_phase[1];
                            next_pb = next_phase[1] ^ next_phase[0];
                        end
                        FMT_CWCCW:
                        begin
                            next_pa = tick & ~axis_ctrl[g].step_dir;
                            next_pb = tick & axis_ctrl[g].step_dir;
                        end
                        default:
                        begin
                            next_pa = tick;
                        end
                    endcase
                end
                else if (axis_ctrl[g].fmt == FMT_AB)
                begin
                    next_pa = phase[1];
                    next_pb = phase[1] ^ phase[0];
                end
            end

            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    vel     <= VEL_ZERO_CODE;                                   // [R1]
                    div_cnt <= 16'h0000;
                    phase   <= 2'h0;
                    pa      <= 1'b0;
                    pb      <= 1'b0;
                end
                else if (ce)
                begin
                    vel     <= next_vel;
                    div_cnt <= next_div_cnt;
                    phase   <= next_phase;
                    pa      <= next_pa;
                    pb      <= next_pb;
                end
            end

            assign axis_velocity_cmd_out[g] = vel;
            assign axis_pulse_cmd_out[g]    = pa;
            assign axis_pulse_cmd_b_out[g]  = pb;
            assign axis_stat[g].enc_count   = enc;
            assign axis_stat[g].pos_limit   = in_s[g];
            assign axis_stat[g].neg_limit   = in_s[4+g];
            assign axis_stat[g].home        = in_s[8+g];

            AST_STOP_ZERO_VEL: assert property (@(posedge clk) disable iff (rst) // [R8]
                (ce && estop_active) |=> (axis_velocity_cmd_out[g] == VEL_ZERO_CODE))
                else $error("velocity not zero during stop");
            AST_OPEN_LOOP_PASS: assert property (@(posedge clk) disable iff (rst) // [R2]
                (ce && !rst && !estop_active && !axis_ctrl[g].loop_en)
                |=> (axis_velocity_cmd_out[g] == $past(axis_ctrl[g].vel_cmd)))
                else $error("open loop command not passed");
            AST_CW_EXCLUSIVE: assert property (@(posedge clk) disable iff (rst) // [R4]
                (axis_ctrl[g].fmt == FMT_CWCCW && $past(axis_ctrl[g].fmt) == FMT_CWCCW)
                |-> !(axis_pulse_cmd_out[g] && axis_pulse_cmd_b_out[g]))
                else $error("cw and ccw both pulsing");
        end
    endgenerate

    // ==========================================================
    // Checks
    AST_RESET_ZERO: assert property (@(posedge clk) // [R1]
        $fell(rst) |-> (axis_velocity_cmd_out[0] == VEL_ZERO_CODE))
        else $error("velocity not zero after reset");
    AST_STOP_PATH: assert property (@(posedge clk) disable iff (rst) // [R8]
        (ce && in_sync[1][12] && !estop_bypass_strap) |=> estop_active)
        else $error("stop not raised");
    AST_STOP_NO_PULSE: assert property (@(posedge clk) disable iff (rst) // [R8]
        (ce && estop_active) ##1 (ce && estop_active) |=> ({axis_pulse_cmd_out, axis_pulse_cmd_b_out} == 8'h00))
        else $error("pulse during stop");
    AST_BYPASS: assert property (@(posedge clk) disable iff (rst) // [R10]
        (ce && estop_bypass_strap) |=> !estop_active)
        else $error("stop acted with strap fitted");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst) // [R9]
        (ce && estop_latched && !estop_latch_clear) |=> estop_latched)
        else $error("latch lost");
    AST_SERVO_OUT: assert property (@(posedge clk) disable iff (rst) // [R13]
        (ce && !rst) |=> (servo_enable_out == $past(servo_enable_value)))
        else $error("servo enable not following");
    AST_READY_OUT: assert property (@(posedge clk) disable iff (rst) // [R14]
        (ce && !rst && !pos_ready_value) |=> !pos_ready_out)
        else $error("ready not asserted");
    AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (rst) // [R15]
        ((ce && !rst) ##1 (ce && !rst)) |=> (in_s[3:0] == $past(positive_limit_in, 2)))
        else $error("limit sync depth wrong");

    COV_STOP: cover property (@(posedge clk) disable iff (rst) $rose(estop_latched));
    COV_CLEAR: cover property (@(posedge clk) disable iff (rst) $fell(estop_latched));
    COV_SERVO: cover property (@(posedge clk) disable iff (rst) $fell(servo_enable_out[0]));
    COV_PULSE: cover property (@(posedge clk) disable iff (rst) $rose(axis_pulse_cmd_out[0]));
endmodule
`default_nettype wire

// ==== sim/field_side_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module field_side_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    output logic            busy,
    output logic [3:0]      phase_a,
    output logic [3:0]      phase_b
);
    // ==========================================================
    // Encoder on all four axes: two full quadrature cycles
    logic [5:0] step;
    logic [5:0] next_step;
    logic       next_busy;

    always_comb
    begin
        next_step = step;
        next_busy = busy;
        if (busy)
        begin
            next_step = step + 6'h01;
            next_busy = (step != 6'h3F);
        end
        else if (run)
        begin
            next_busy = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            step <= '0;
            busy <= 1'b0;
        end
        else
        begin
            step <= next_step;
            busy <= next_busy;
        end
    end

    // B leads A, so every edge is one step forward
    assign phase_a = {4{step[4]}};
    assign phase_b = {4{step[4] ^ step[3]}};
endmodule
`default_nettype wire

// ==== sim/four_axis_servo_io_control_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module four_axis_servo_io_control_bench;
    import servo_io_pkg::*;
    typedef struct {logic [15:0] vel; logic [3:0] srv; logic rdy;} row_t;
    logic clk = 0, rst = 1, ce = 1, lclr = 0, strap = 1, estop = 0, rdy = 1, run = 0, busy;
    logic [3:0]   srv = 4'hF, plim = 4'hF, nlim = 4'hF, home = 4'hF, pa, pb, pls, plsb, srvo;
    logic         rdyo, eact, elat;
    axis_ctrl_t [3:0] ctrl = '0;
    axis_stat_t [3:0] stat;
    logic [3:0][15:0] vel;
    int mismatches = 0, total_checks = 0, ra[4], rb[4], tog;
    row_t rows[4] = '{'{16'h1234, 4'hE, 1'b1}, '{16'hFFFF, 4'h0, 1'b0},
                      '{16'h0000, 4'hA, 1'b1}, '{16'h8000, 4'h5, 1'b0}};
    always #5 clk = ~clk;

    field_side_model partner (.clk(clk), .rst(rst), .run(run), .busy(busy), .phase_a(pa), .phase_b(pb));
    four_axis_servo_io_control uut (.clk(clk), .rst(rst), .ce(ce), .axis_ctrl(ctrl),
        .servo_enable_value(srv), .pos_ready_value(rdy), .estop_latch_clear(lclr),
        .estop_bypass_strap(strap), .positive_limit_in(plim), .negative_limit_in(nlim),
        .home_in(home), .estop_in(estop), .axis_encoder_phase_a_in(pa), .axis_encoder_phase_b_in(pb),
        .axis_velocity_cmd_out(vel), .axis_pulse_cmd_out(pls), .axis_pulse_cmd_b_out(plsb),
        .servo_enable_out(srvo), .pos_ready_out(rdyo), .axis_stat(stat),
        .estop_active(eact), .estop_latched(elat));

    // ==========================================================
    // Shared helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic count_pulses(input int n);
        logic [3:0] pa0, pb0;
        ra = '{0, 0, 0, 0};
        rb = '{0, 0, 0, 0};
        tog = 0;
        for (int c = 0; c < n; c++)
        begin
            pa0 = pls;
            pb0 = plsb;
            cyc(1);
            for (int i = 0; i < 4; i++)
            begin
                ra[i] += (pls[i] && !pa0[i]);
                rb[i] += (plsb[i] && !pb0[i]);
            end
            tog += (pls[0] != pa0[0]) + (plsb[0] != pb0[0]);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        stop_test();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        for (int i = 0; i < 4; i++)
            chk("vel reset", 16'h8000, vel[i]);
        chk("outs reset", 5'h1F, {srvo, rdyo});
        chk("stop reset", 2'b00, {eact, elat});
        $display("test reset done");

        foreach (rows[r])
        begin
            @(posedge clk);
            for (int i = 0; i < 4; i++)
                ctrl[i].vel_cmd <= rows[r].vel ^ i[15:0];
            srv <= rows[r].srv;
            rdy <= rows[r].rdy;
            cyc(2);
            for (int i = 0; i < 4; i++)
                chk("vel cmd", rows[r].vel ^ i[15:0], vel[i]);
            chk("servo on", rows[r].srv, srvo);
            chk("ready", rows[r].rdy, rdyo);
        end
        $display("test table done");

        @(posedge clk);
        plim <= 4'h6;
        nlim <= 4'hA;
        home <= 4'h3;
        cyc(6);
        for (int i = 0; i < 4; i++)
            chk("switches", {plim[i], nlim[i], home[i]}, stat[i][2:0]);
        $display("test switches done");

        @(posedge clk);
        ctrl[1].mult <= MULT_X1;
        ctrl[2].mult <= MULT_X2;
        ctrl[3].mult <= MULT_X4;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        cyc(80);
        chk("enc x0", 0, stat[0].enc_count);
        chk("enc x1", 2, stat[1].enc_count);
        chk("enc x2", 4, stat[2].enc_count);
        chk("enc x4", 8, stat[3].enc_count);
        $display("test encoder done");

        @(posedge clk);
        ctrl[1].fmt <= FMT_CWCCW;
        ctrl[1].step_dir <= 1'b1;
        ctrl[2].fmt <= FMT_PULSEDIR;
        ctrl[2].step_dir <= 1'b1;
        ctrl[3].fmt <= FMT_CWCCW;
        for (int i = 0; i < 4; i++)
        begin
            ctrl[i].rate_div <= 16'h0003;
            ctrl[i].step_req <= 1'b1;
        end
        estop <= 1'b1;
        cyc(8);
        count_pulses(40);
        chk("bypass", 1'b0, eact);
        chk("ab steps", 1, tog >= 9 && tog <= 11);
        chk("ccw", 1, rb[1] >= 9 && rb[1] <= 11 && ra[1] == 0);
        chk("pdir", 2'b11, {ra[2] >= 9 && ra[2] <= 11, plsb[2]});
        chk("cw", 1, ra[3] >= 9 && ra[3] <= 11 && rb[3] == 0);
        $display("test pulses done");

        @(posedge clk);
        strap <= 1'b0;
        cyc(4);
        chk("stop act", 2'b11, {eact, elat});
        cyc(3);
        for (int c = 0; c < 8; c++)
        begin
            chk("pulse off", 8'h00, {pls, plsb});
            for (int i = 0; i < 4; i++)
                chk("vel zero", 16'h8000, vel[i]);
            cyc(1);
        end
        @(posedge clk);
        estop <= 1'b0;
        cyc(6);
        chk("latch held", 2'b01, {eact, elat});
        @(posedge clk);
        lclr <= 1'b1;
        @(posedge clk);
        lclr <= 1'b0;
        cyc(2);
        chk("latch clr", 1'b0, elat);
        $display("test stop done");

        @(posedge clk);
        ctrl[0].loop_en <= 1'b1;
        ctrl[0].kp <= 8'h01;
        ctrl[0].pos_target <= 16'h0010;
        cyc(4);
        chk("loop on", 16'h8010, vel[0]);
        chk("loop off", 16'h8000 ^ 16'h0001, vel[1]);
        $display("test loop done");

        @(posedge clk);
        ce  <= 1'b0;
        srv <= 4'h3;
        cyc(3);
        chk("ce hold", 4'h5, srvo);
        @(posedge clk);
        ce <= 1'b1;
        cyc(2);
        chk("ce run", 4'h3, srvo);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("vel rerun", 16'h8000, vel[1]);
        cyc(4);
        chk("stop after reset", 2'b00, {eact, elat});
        $display("test enable and reset done");
        stop_test();
    end
endmodule
`default_nettype wire
